//--- core/pisr_info_capture.sv
`timescale 1ns/100ps
module pisr_info_capture
    import pisr_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic restore_user_i,
    input  wire logic bulk_read_i,
    input  wire logic ecc_corrected_i,
    output logic      ecc_clean_o
);

    pisr_info_state_t state_ff;
    pisr_info_state_t nxt_state;
    logic             clean_ff;
    logic             nxt_clean;

    // the first clock after reset release stands for the power-on refresh
    always_comb begin
        nxt_state = state_ff;
        nxt_clean = clean_ff;
        case (state_ff)
            INF_BOOT: begin
                nxt_clean = ~ecc_corrected_i;
                nxt_state = INF_RUN;
            end
            INF_RUN: begin
                if (restore_user_i || bulk_read_i) begin
                    nxt_clean = ~ecc_corrected_i;
                end
            end
            default: nxt_state = INF_BOOT;
        endcase
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_ff <= INF_BOOT;
            clean_ff <= INFO_ECC_RST;
        end else begin
            state_ff <= nxt_state;
            clean_ff <= nxt_clean;
        end
    end

    assign ecc_clean_o = clean_ff;

    property p_refresh;
        @(posedge clk_i) disable iff (reset_i)
        (state_ff == INF_RUN) && (restore_user_i || bulk_read_i)
            |=> (ecc_clean_o == !$past(ecc_corrected_i));
    endproperty
    a_refresh: assert property (p_refresh)
        else $error("ecc status not refreshed");

    property p_hold;
        @(posedge clk_i) disable iff (reset_i)
        (state_ff == INF_RUN) && !restore_user_i && !bulk_read_i |=> $stable(ecc_clean_o);
    endproperty
    a_hold: assert property (p_hold)
        else $error("ecc status changed without refresh");

endmodule // pisr_info_capture

//--- core/pisr_pkg.sv
package pisr_pkg;

    // command codes
    localparam logic [7:0] CMD_FEATURE  = 8'h19;
    localparam logic [7:0] CMD_BUS_REV  = 8'h98;
    localparam logic [7:0] CMD_MAKER_ID = 8'hE7;
    localparam logic [7:0] CMD_LOT      = 8'hE8;
    localparam logic [7:0] CMD_INFO     = 8'hB6;
    localparam logic [7:0] CMD_TOOL_A   = 8'hB0;
    localparam logic [7:0] CMD_TOOL_B   = 8'hB1;
    localparam logic [7:0] CMD_OEM      = 8'hB2;
    localparam logic [7:0] CMD_SCR_PG   = 8'hB3;
    localparam logic [7:0] CMD_SCR_GL   = 8'hB4;
    localparam logic [7:0] CMD_RES1     = 8'hB5;
    localparam logic [7:0] CMD_RES2     = 8'hBC;

    // feature summary byte fields
    localparam int         FEAT_PEC_POS   = 7;
    localparam int         FEAT_SCL_LSB   = 5;
    localparam int         FEAT_ALERT_POS = 4;
    localparam logic       FEAT_PEC       = 1'h1;
    localparam logic [1:0] FEAT_SCL_400K  = 2'h1;
    localparam logic       FEAT_ALERT     = 1'h1;
    localparam logic [3:0] FEAT_RSVD      = 4'h0;
    localparam logic [7:0] FEATURE_VAL    = {FEAT_PEC, FEAT_SCL_400K, FEAT_ALERT, FEAT_RSVD};

    localparam logic [7:0]  BUS_REV_VAL   = 8'h11;
    // identification code: value is arbitrary
    localparam logic [15:0] MAKER_ID_VAL  = 16'h5A3C;

    // maker info word
    localparam int   INFO_ECC_POS = 5;
    localparam logic INFO_ECC_RST = 1'h1;

    // reset values
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [7:0]  LOT_RST  = 8'h00;

    localparam int NUM_PAGES = 4;

    typedef logic [15:0] pisr_word_t;
    typedef logic [1:0]  pisr_page_t;

    typedef enum logic [1:0] {
        INF_BOOT = 2'b00,
        INF_RUN  = 2'b01
    } pisr_info_state_t;

endpackage

//--- core/pisr_regs.sv
`timescale 1ns/100ps
// Functional notes
// - The feature byte always reads with bit 7 set, advertising error checking support.
// - Whether error checking is required is not shown in the feature byte at all.
// - Feature bits 6:5 always read 01b, a 400 kHz bus ceiling.
// - Feature bit 4 reads 1 for alert support and bits 3:0 read zero.
// - The feature byte is read-only at code 0x19 and always holds 0xB0.
// - The bus standard version byte is read-only at code 0x98 and holds 0x11.
// - The maker identifier word is read-only at code 0xE7 and always the same.
// - The factory lot byte is read-only, nonvolatile and holds one value per page.
// - The maker info word is refreshed after reset, user reload and bulk reads.
// - Maker info bit 5 reads 0 after ECC corrections and 1 without; others are 0.
// - Scratch words at 0xB3 (paged) and 0xB4 (unpaged) are read/write, reset 0x0000.
// - Scratch storage is ten bytes: one global word and four independent page words.
// - Read/write words also sit at 0xB0-0xB2, 0xB5 and 0xBC, paged at 0xB1/0xB5/0xBC.
module pisr_regs
    import pisr_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        cmd_valid_i,
    input  wire logic        cmd_write_i,
    input  wire logic [7:0]  cmd_code_i,
    input  wire logic [1:0]  cmd_page_i,
    input  wire logic [15:0] cmd_wdata_i,
    input  wire logic        nv_load_i,
    input  wire logic [7:0]  nv_code_i,
    input  wire logic [1:0]  nv_page_i,
    input  wire logic [15:0] nv_data_i,
    input  wire logic        restore_user_i,
    input  wire logic        bulk_read_i,
    input  wire logic        ecc_corrected_i,
    output logic             rsp_valid_o,
    output logic [15:0]      rsp_data_o,
    output logic             rsp_err_o
);

    pisr_word_t tool_a_ff;
    pisr_word_t nxt_tool_a;
    pisr_word_t oem_ff;
    pisr_word_t nxt_oem;
    pisr_word_t scr_gl_ff;
    pisr_word_t nxt_scr_gl;
    pisr_word_t tool_b_ff  [NUM_PAGES];
    pisr_word_t nxt_tool_b [NUM_PAGES];
    pisr_word_t scr_pg_ff  [NUM_PAGES];
    pisr_word_t nxt_scr_pg [NUM_PAGES];
    pisr_word_t res1_ff    [NUM_PAGES];
    pisr_word_t nxt_res1   [NUM_PAGES];
    pisr_word_t res2_ff    [NUM_PAGES];
    pisr_word_t nxt_res2   [NUM_PAGES];
    logic [7:0] lot_ff     [NUM_PAGES];
    logic [7:0] nxt_lot    [NUM_PAGES];

    logic       rsp_valid_ff;
    logic       nxt_rsp_valid;
    pisr_word_t rsp_data_ff;
    pisr_word_t nxt_rsp_data;
    logic       rsp_err_ff;
    logic       nxt_rsp_err;
    logic       ecc_clean;
    logic       host_wr;

    function automatic logic is_ro(input logic [7:0] code);
        return (code == CMD_FEATURE) || (code == CMD_BUS_REV) || (code == CMD_MAKER_ID)
            || (code == CMD_LOT) || (code == CMD_INFO);
    endfunction

    function automatic logic is_rw(input logic [7:0] code);
        return (code == CMD_TOOL_A) || (code == CMD_TOOL_B) || (code == CMD_OEM)
            || (code == CMD_SCR_PG) || (code == CMD_SCR_GL) || (code == CMD_RES1)
            || (code == CMD_RES2);
    endfunction

    pisr_info_capture pisr_info_capture_inst (
        .clk_i           (clk_i),
        .reset_i         (reset_i),
        .restore_user_i  (restore_user_i),
        .bulk_read_i     (bulk_read_i),
        .ecc_corrected_i (ecc_corrected_i),
        .ecc_clean_o     (ecc_clean)
    );

    assign host_wr = cmd_valid_i && cmd_write_i;

    // storage: eeprom image loads first, a host write in the same cycle wins
    always_comb begin
        nxt_tool_a = tool_a_ff;
        nxt_oem    = oem_ff;
        nxt_scr_gl = scr_gl_ff;
        nxt_tool_b = tool_b_ff;
        nxt_scr_pg = scr_pg_ff;
        nxt_res1   = res1_ff;
        nxt_res2   = res2_ff;
        nxt_lot    = lot_ff;
        if (nv_load_i) begin
            if (nv_code_i == CMD_TOOL_A) begin
                nxt_tool_a = nv_data_i;
            end else if (nv_code_i == CMD_TOOL_B) begin
                nxt_tool_b[nv_page_i] = nv_data_i;
            end else if (nv_code_i == CMD_OEM) begin
                nxt_oem = nv_data_i;
            end else if (nv_code_i == CMD_SCR_PG) begin
                nxt_scr_pg[nv_page_i] = nv_data_i;
            end else if (nv_code_i == CMD_SCR_GL) begin
                nxt_scr_gl = nv_data_i;
            end else if (nv_code_i == CMD_RES1) begin
                nxt_res1[nv_page_i] = nv_data_i;
            end else if (nv_code_i == CMD_LOT) begin
                nxt_lot[nv_page_i] = nv_data_i[7:0];
            end
            // the 0xBC word has no eeprom copy, so the image never loads it
        end
        if (host_wr && is_rw(cmd_code_i)) begin
            if (cmd_code_i == CMD_TOOL_A) begin
                nxt_tool_a = cmd_wdata_i;
            end else if (cmd_code_i == CMD_TOOL_B) begin
                nxt_tool_b[cmd_page_i] = cmd_wdata_i;
            end else if (cmd_code_i == CMD_OEM) begin
                nxt_oem = cmd_wdata_i;
            end else if (cmd_code_i == CMD_SCR_PG) begin
                nxt_scr_pg[cmd_page_i] = cmd_wdata_i;
            end else if (cmd_code_i == CMD_SCR_GL) begin
                nxt_scr_gl = cmd_wdata_i;
            end else if (cmd_code_i == CMD_RES1) begin
                nxt_res1[cmd_page_i] = cmd_wdata_i;
            end else begin
                nxt_res2[cmd_page_i] = cmd_wdata_i;
            end
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            tool_a_ff <= WORD_RST;
            oem_ff    <= WORD_RST;
            scr_gl_ff <= WORD_RST;
            for (int i = 0; i < NUM_PAGES; i++) begin
                tool_b_ff[i] <= WORD_RST;
                scr_pg_ff[i] <= WORD_RST;
                res1_ff[i]   <= WORD_RST;
                res2_ff[i]   <= WORD_RST;
                lot_ff[i]    <= LOT_RST;
            end
        end else begin
            tool_a_ff <= nxt_tool_a;
            oem_ff    <= nxt_oem;
            scr_gl_ff <= nxt_scr_gl;
            tool_b_ff <= nxt_tool_b;
            scr_pg_ff <= nxt_scr_pg;
            res1_ff   <= nxt_res1;
            res2_ff   <= nxt_res2;
            lot_ff    <= nxt_lot;
        end
    end

    // one answer per request, the cycle after; writes answer with zero data
    always_comb begin
        nxt_rsp_valid = cmd_valid_i;
        nxt_rsp_data  = WORD_RST;
        nxt_rsp_err   = 1'b0;
        if (cmd_valid_i && cmd_write_i) begin
            nxt_rsp_err = !is_rw(cmd_code_i);
        end else if (cmd_valid_i) begin
            nxt_rsp_err = !(is_rw(cmd_code_i) || is_ro(cmd_code_i));
            if (cmd_code_i == CMD_FEATURE) begin
                // built from constants only; pec-required lives elsewhere
                nxt_rsp_data = {8'h00, FEATURE_VAL};
            end else if (cmd_code_i == CMD_BUS_REV) begin
                nxt_rsp_data = {8'h00, BUS_REV_VAL};
            end else if (cmd_code_i == CMD_MAKER_ID) begin
                nxt_rsp_data = MAKER_ID_VAL;
            end else if (cmd_code_i == CMD_LOT) begin
                nxt_rsp_data = {8'h00, lot_ff[cmd_page_i]};
            end else if (cmd_code_i == CMD_INFO) begin
                nxt_rsp_data[INFO_ECC_POS] = ecc_clean;
            end else if (cmd_code_i == CMD_TOOL_A) begin
                nxt_rsp_data = tool_a_ff;
            end else if (cmd_code_i == CMD_TOOL_B) begin
                nxt_rsp_data = tool_b_ff[cmd_page_i];
            end else if (cmd_code_i == CMD_OEM) begin
                nxt_rsp_data = oem_ff;
            end else if (cmd_code_i == CMD_SCR_PG) begin
                nxt_rsp_data = scr_pg_ff[cmd_page_i];
            end else if (cmd_code_i == CMD_SCR_GL) begin
                nxt_rsp_data = scr_gl_ff;
            end else if (cmd_code_i == CMD_RES1) begin
                nxt_rsp_data = res1_ff[cmd_page_i];
            end else if (cmd_code_i == CMD_RES2) begin
                nxt_rsp_data = res2_ff[cmd_page_i];
            end
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rsp_valid_ff <= 1'b0;
            rsp_data_ff  <= WORD_RST;
            rsp_err_ff   <= 1'b0;
        end else begin
            rsp_valid_ff <= nxt_rsp_valid;
            rsp_data_ff  <= nxt_rsp_data;
            rsp_err_ff   <= nxt_rsp_err;
        end
    end

    assign rsp_valid_o = rsp_valid_ff;
    assign rsp_data_o  = rsp_data_ff;
    assign rsp_err_o   = rsp_err_ff;

    // helpers for the checks below
    logic       rd_req;
    pisr_word_t scr_other;
    logic [1:0] page_other;

    assign rd_req     = cmd_valid_i && !cmd_write_i;
    assign page_other = cmd_page_i ^ 2'h1;
    assign scr_other  = scr_pg_ff[page_other];

    property p_feat_pec;
        @(posedge clk_i) disable iff (reset_i)
        rd_req && (cmd_code_i == CMD_FEATURE) |=> rsp_valid_o && rsp_data_o[FEAT_PEC_POS];
    endproperty
    a_feat_pec: assert property (p_feat_pec)
        else $error("feature byte lost pec bit");

    property p_feat_scl;
        @(posedge clk_i) disable iff (reset_i)
        rd_req && (cmd_code_i == CMD_FEATURE)
            |=> rsp_data_o[FEAT_SCL_LSB +: 2] == 2'h1;
    endproperty
    a_feat_scl: assert property (p_feat_scl)
        else $error("feature bus speed field wrong");

    property p_feat_low;
        @(posedge clk_i) disable iff (reset_i)
        rd_req && (cmd_code_i == CMD_FEATURE)
            |=> rsp_data_o[FEAT_ALERT_POS] && (rsp_data_o[3:0] == 4'h0);
    endproperty
    a_feat_low: assert property (p_feat_low)
        else $error("feature alert or reserved bits wrong");

    property p_feat_val;
        @(posedge clk_i) disable iff (reset_i)
        rd_req && (cmd_code_i == CMD_FEATURE)
            |=> (rsp_data_o == 16'h00B0) && !rsp_err_o;
    endproperty
    a_feat_val: assert property (p_feat_val)
        else $error("feature byte not 0xB0");

    property p_rev;
        @(posedge clk_i) disable iff (reset_i)
        rd_req && (cmd_code_i == CMD_BUS_REV) |=> rsp_data_o == 16'h0011;
    endproperty
    a_rev: assert property (p_rev)
        else $error("bus revision not 0x11");

    property p_id;
        @(posedge clk_i) disable iff (reset_i)
        rd_req && (cmd_code_i == CMD_MAKER_ID) |=> rsp_data_o == MAKER_ID_VAL;
    endproperty
    a_id: assert property (p_id)
        else $error("maker identifier changed");

    property p_lot;
        @(posedge clk_i) disable iff (reset_i)
        rd_req && (cmd_code_i == CMD_LOT)
            |=> rsp_data_o == {8'h00, $past(lot_ff[cmd_page_i])};
    endproperty
    a_lot: assert property (p_lot)
        else $error("lot code read wrong page");

    property p_info;
        @(posedge clk_i) disable iff (reset_i)
        rd_req && (cmd_code_i == CMD_INFO)
            |=> rsp_data_o == {10'h000, $past(ecc_clean), 5'h00};
    endproperty
    a_info: assert property (p_info)
        else $error("maker info word layout wrong");

    property p_scr_wr;
        @(posedge clk_i) disable iff (reset_i)
        host_wr && (cmd_code_i == CMD_SCR_PG)
            |=> scr_pg_ff[$past(cmd_page_i)] == $past(cmd_wdata_i);
    endproperty
    a_scr_wr: assert property (p_scr_wr)
        else $error("paged scratch write lost");

    property p_scr_indep;
        @(posedge clk_i) disable iff (reset_i)
        host_wr && (cmd_code_i == CMD_SCR_PG) && !nv_load_i
            |=> scr_pg_ff[$past(page_other)] == $past(scr_other);
    endproperty
    a_scr_indep: assert property (p_scr_indep)
        else $error("scratch write disturbed another page");

    property p_res2;
        @(posedge clk_i) disable iff (reset_i)
        host_wr && (cmd_code_i == CMD_RES2)
            |=> res2_ff[$past(cmd_page_i)] == $past(cmd_wdata_i);
    endproperty
    a_res2: assert property (p_res2)
        else $error("reserved paged word write lost");

    property p_ro_wr;
        @(posedge clk_i) disable iff (reset_i)
        host_wr && is_ro(cmd_code_i) && !nv_load_i
            |=> rsp_err_o && $stable(scr_gl_ff) && $stable(tool_a_ff) && $stable(oem_ff);
    endproperty
    a_ro_wr: assert property (p_ro_wr)
        else $error("read-only write had an effect");

endmodule // pisr_regs

//--- tb/pisr_host_model.sv
`timescale 1ns/100ps
module pisr_host_model (
    input  wire logic   clk_i,
    output logic        cmd_valid_o,
    output logic        cmd_write_o,
    output logic [7:0]  cmd_code_o,
    output logic [1:0]  cmd_page_o,
    output logic [15:0] cmd_wdata_o
);
    initial begin
        cmd_valid_o = 1'h0;
        cmd_write_o = 1'h0;
        cmd_code_o  = 8'h00;
        cmd_page_o  = 2'h0;
        cmd_wdata_o = 16'h0000;
    end

    // one command per edge; the block never stalls, so no ready to wait for
    task automatic issue(input logic wr, input logic [7:0] code, input logic [1:0] pg,
                         input logic [15:0] wd);
        @(posedge clk_i);
        cmd_valid_o <= 1'h1;
        cmd_write_o <= wr;
        cmd_code_o  <= code;
        cmd_page_o  <= pg;
        cmd_wdata_o <= wd;
    endtask

    // released lines show the inverse, so a stale copy is never mistaken for data
    task automatic release_bus();
        @(posedge clk_i);
        cmd_valid_o <= 1'h0;
        cmd_write_o <= ~cmd_write_o;
        cmd_code_o  <= ~cmd_code_o;
        cmd_page_o  <= ~cmd_page_o;
        cmd_wdata_o <= ~cmd_wdata_o;
    endtask
endmodule // pisr_host_model

//--- tb/pisr_regs_test.sv
`timescale 1ns/100ps
module pisr_regs_test;
    import pisr_pkg::*;
    typedef struct packed {
        logic [15:0] data;
        logic        err;
    } pisr_exp_t;

    logic        clk_i, reset_i, cmd_valid_i, cmd_write_i;
    logic [7:0]  cmd_code_i, nv_code_i;
    logic [1:0]  cmd_page_i, nv_page_i;
    logic [15:0] cmd_wdata_i, nv_data_i, rsp_data_o, v;
    logic        nv_load_i, restore_user_i, bulk_read_i, ecc_corrected_i;
    logic        rsp_valid_o, rsp_err_o;
    pisr_exp_t   exp_q[$];
    pisr_exp_t   cur;
    logic [15:0] mem [256][4];
    int          n_mismatch, cmp_count, i, pg;
    logic [7:0]  ro_codes [5] = '{CMD_FEATURE, CMD_BUS_REV, CMD_MAKER_ID, CMD_LOT, CMD_INFO};
    logic [7:0]  rw_codes [7] = '{CMD_TOOL_A, CMD_TOOL_B, CMD_OEM, CMD_SCR_PG, CMD_SCR_GL,
                                  CMD_RES1, CMD_RES2};

    pisr_regs pisr_regs_inst (.clk_i(clk_i), .reset_i(reset_i), .cmd_valid_i(cmd_valid_i),
        .cmd_write_i(cmd_write_i), .cmd_code_i(cmd_code_i), .cmd_page_i(cmd_page_i),
        .cmd_wdata_i(cmd_wdata_i), .nv_load_i(nv_load_i), .nv_code_i(nv_code_i),
        .nv_page_i(nv_page_i), .nv_data_i(nv_data_i), .restore_user_i(restore_user_i),
        .bulk_read_i(bulk_read_i), .ecc_corrected_i(ecc_corrected_i),
        .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .rsp_err_o(rsp_err_o));

    pisr_host_model pisr_host_model_inst (.clk_i(clk_i), .cmd_valid_o(cmd_valid_i),
        .cmd_write_o(cmd_write_i), .cmd_code_o(cmd_code_i), .cmd_page_o(cmd_page_i),
        .cmd_wdata_o(cmd_wdata_i));

    initial begin
        clk_i = 1'h0;
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // unpaged words live in slot 0 whatever page the host sends
    function automatic int slot(input logic [7:0] c, input logic [1:0] p);
        return (c == CMD_TOOL_B || c == CMD_SCR_PG || c == CMD_RES1 || c == CMD_RES2 ||
                c == CMD_LOT) ? int'(p) : 0;
    endfunction

    task automatic rd(input logic [7:0] c, input logic [1:0] p, input logic [15:0] e,
                      input logic er);
        exp_q.push_back(pisr_exp_t'{e, er});
        pisr_host_model_inst.issue(1'h0, c, p, 16'($urandom));
    endtask

    task automatic rdm(input logic [7:0] c, input logic [1:0] p);
        rd(c, p, mem[c][slot(c, p)], 1'h0);
    endtask

    task automatic wr(input logic [7:0] c, input logic [1:0] p, input logic [15:0] d,
                      input logic er);
        exp_q.push_back(pisr_exp_t'{16'h0000, er});
        if (!er) mem[c][slot(c, p)] = d;
        pisr_host_model_inst.issue(1'h1, c, p, d);
    endtask

    task automatic drain();
        int n;
        pisr_host_model_inst.release_bus();
        for (n = 0; n < 20 && exp_q.size() != 0; n++) @(posedge clk_i);
        if (exp_q.size() != 0) begin
            check("pending answers", 16'(exp_q.size()), 16'h0000);
            test_done();
        end
    endtask

    task automatic nv(input logic [7:0] c, input logic [1:0] p, input logic [15:0] d);
        @(posedge clk_i);
        nv_load_i <= 1'h1;
        nv_code_i <= c;
        nv_page_i <= p;
        nv_data_i <= d;
        @(posedge clk_i);
        nv_load_i <= 1'h0;
        if (c == CMD_LOT) mem[c][slot(c, p)] = {8'h00, d[7:0]};
        else if (c inside {CMD_TOOL_A, CMD_TOOL_B, CMD_OEM, CMD_SCR_PG, CMD_SCR_GL, CMD_RES1})
            mem[c][slot(c, p)] = d;
    endtask

    task automatic evt(input logic ecc, input logic rs, input logic bk);
        @(posedge clk_i);
        ecc_corrected_i <= ecc;
        restore_user_i  <= rs;
        bulk_read_i     <= bk;
        @(posedge clk_i);
        restore_user_i  <= 1'h0;
        bulk_read_i     <= 1'h0;
    endtask

    task automatic do_reset();
        @(posedge clk_i);
        reset_i <= 1'h1;
        repeat (5) @(posedge clk_i);
        reset_i <= 1'h0;
        foreach (mem[a, b]) mem[a][b] = 16'h0000;
    endtask

    // answers are checked mid-cycle, after the registered outputs have settled
    always @(negedge clk_i) begin
        if (rsp_valid_o === 1'h1) begin
            if (exp_q.size() == 0) begin
                check("rsp_valid_o", 16'h0001, 16'h0000);
            end else begin
                cur = exp_q.pop_front();
                check("rsp_data_o", rsp_data_o, cur.data);
                check("rsp_err_o", {15'h0000, rsp_err_o}, {15'h0000, cur.err});
            end
        end
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        check("run length", 16'h0001, 16'h0000);
        test_done();
    end

    initial begin
        reset_i = 1'h1;
        nv_load_i = 1'h0;
        nv_code_i = 8'h00;
        nv_page_i = 2'h0;
        nv_data_i = 16'h0000;
        restore_user_i = 1'h0;
        bulk_read_i = 1'h0;
        ecc_corrected_i = 1'h0;
        void'($urandom(32'h1BBDADC6));
        do_reset();
        rd(CMD_INFO, 2'h0, 16'h0020, 1'h0);
        rd(CMD_FEATURE, 2'h0, {8'h00, 1'h1, 2'h1, 1'h1, 4'h0}, 1'h0);
        rd(CMD_BUS_REV, 2'h0, 16'h0011, 1'h0);
        rd(CMD_MAKER_ID, 2'h0, MAKER_ID_VAL, 1'h0);
        for (pg = 0; pg < 4; pg++) rdm(CMD_SCR_PG, 2'(pg));
        rdm(CMD_SCR_GL, 2'h3);
        rd(8'h00, 2'h0, 16'h0000, 1'h1);
        for (i = 0; i < 5; i++) wr(ro_codes[i], 2'h1, 16'($urandom), 1'h1);
        rd(CMD_FEATURE, 2'h2, {8'h00, 1'h1, 2'h1, 1'h1, 4'h0}, 1'h0);
        rd(CMD_MAKER_ID, 2'h1, MAKER_ID_VAL, 1'h0);
        rdm(CMD_LOT, 2'h1);
        drain();
        for (i = 0; i < 7; i++) begin
            for (pg = 0; pg < 4; pg++) begin
                wr(rw_codes[i], 2'(pg), 16'($urandom), 1'h0);
                rdm(rw_codes[i], 2'(pg));
            end
        end
        for (i = 0; i < 7; i++) begin
            for (pg = 0; pg < 4; pg++) rdm(rw_codes[i], 2'(3 - pg));
        end
        drain();
        nv(CMD_LOT, 2'h1, 16'h0042);
        nv(CMD_SCR_PG, 2'h2, 16'($urandom));
        nv(CMD_RES2, 2'h0, 16'($urandom));
        nv(CMD_TOOL_A, 2'h1, 16'($urandom));
        nv(CMD_TOOL_B, 2'h3, 16'($urandom));
        nv(CMD_OEM, 2'h2, 16'($urandom));
        nv(CMD_RES1, 2'h1, 16'($urandom));
        nv(CMD_MAKER_ID, 2'h0, 16'($urandom));
        for (pg = 0; pg < 4; pg++) rdm(CMD_LOT, 2'(pg));
        rdm(CMD_SCR_PG, 2'h2);
        rdm(CMD_RES2, 2'h0);
        rdm(CMD_TOOL_A, 2'h0);
        rdm(CMD_TOOL_B, 2'h3);
        rdm(CMD_OEM, 2'h0);
        rdm(CMD_RES1, 2'h1);
        rd(CMD_MAKER_ID, 2'h0, MAKER_ID_VAL, 1'h0);
        drain();
        // eeprom load and host write on one word in one cycle: the host write wins
        v = 16'($urandom);
        fork
            nv(CMD_SCR_GL, 2'h0, ~v);
            begin
                wr(CMD_SCR_GL, 2'h0, v, 1'h0);
                pisr_host_model_inst.release_bus();
            end
        join
        mem[CMD_SCR_GL][0] = v;
        rdm(CMD_SCR_GL, 2'h1);
        drain();
        evt(1'h1, 1'h1, 1'h0);
        rd(CMD_INFO, 2'h0, 16'h0000, 1'h0);
        drain();
        evt(1'h0, 1'h0, 1'h0);
        rd(CMD_INFO, 2'h0, 16'h0000, 1'h0);
        drain();
        evt(1'h0, 1'h0, 1'h1);
        rd(CMD_INFO, 2'h0, 16'h0020, 1'h0);
        drain();
        evt(1'h1, 1'h0, 1'h1);
        rd(CMD_INFO, 2'h0, 16'h0000, 1'h0);
        drain();
        evt(1'h0, 1'h0, 1'h0);
        do_reset();
        rdm(CMD_SCR_GL, 2'h0);
        rdm(CMD_SCR_PG, 2'h2);
        rd(CMD_INFO, 2'h0, 16'h0020, 1'h0);
        drain();
        test_done();
    end
endmodule // pisr_regs_test
